// ---- logic/osc_ctrl.sv ----
// Operation
// RULE_01: Oscillator control register sits at 25h.
// RULE_02: Bit 7 inverts clock output; jitter edge follows.
// RULE_03: Inversion applies to selected output frequency.
// RULE_04: Bit 6 selects offset calibration mode.
// RULE_05: Bit 5: 0 gives 24h, 1 gives 12h.
// RULE_06: 12h counting uses an afternoon flag.
// RULE_07: Hour format ignored in stop-watch mode.
// RULE_08: Bit 4 selects low-jitter clock output.
// RULE_09: Drive code: 00 normal, 01 low, 1x high.
// RULE_10: Cap code: 00 7.0, 01 6.0, 1x 12.5 pF.
// RULE_11: Software uses 7.0 pF for 9.0 pF crystals.
// RULE_12: Fields read back last written value.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`include "osc_ctrl_map.svh"
module osc_ctrl
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire logic src_clk_in,
   input wire logic [4:0] hour_count_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic clk_out,
   output logic low_jitter_select_out,
   output logic offset_cal_mode_out,
   output osc_ctrl_pkg::drive_t crystal_drive_level_out,
   output osc_ctrl_pkg::cap_t load_cap_select_out,
   output osc_ctrl_pkg::hour_mode_t hour_mode_out,
   output logic [4:0] hour_display_out,
   output logic afternoon_flag_out
);
   import osc_ctrl_pkg::*;
   osc_field_if fields();
   logic [7:0] osc_reg;
   logic [7:0] osc_next;
   logic [7:0] func_reg;
   logic [7:0] func_next;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_next;
   logic src_s1_reg;
   logic src_s2_reg;
   logic [4:0] hour_s1_reg;
   logic [4:0] hour_s2_reg;
   wire addr_phase;
   wire [7:0] word_index;
   wire hit_osc;
   wire hit_func;
   wire hit_status;
   wire wr_osc;
   wire wr_func;
   wire clk_sel;
   wire [4:0] hour12;
   wire pm;
   osc_field_decode u_decode
   (
      .f(fields)
   );
   assign fields.raw = osc_reg;
   assign fields.stopwatch = func_reg[`STOPWATCH_BIT];
   assign addr_phase = hsel_in && hready_in && htrans_in[1];
   // Registers hold word indices: printed offsets are not word aligned
   assign word_index = haddr_in[`ADDR_HI:`ADDR_LO];
   assign hit_osc = word_index == `OSC_CTRL_ADDR; // RULE_01
   assign hit_func = word_index == `FUNC_ADDR;
   assign hit_status = word_index == `STATUS_ADDR;
   assign wr_osc = wr_pend_reg && (wr_addr_reg == `OSC_CTRL_ADDR);
   assign wr_func = wr_pend_reg && (wr_addr_reg == `FUNC_ADDR);
   assign osc_next = wr_osc ? hwdata_in[7:0] : osc_reg; // RULE_12
   assign func_next = wr_func ? hwdata_in[7:0] : func_reg;
   // Hour count bit 0 stands in for the output frequency select
   assign clk_sel = (func_reg[`COF_HI:`COF_LO] == 3'h0) ? src_s2_reg :
      hour_s2_reg[0]; // RULE_03
   assign pm = hour_s2_reg >= 5'd12; // RULE_06
   assign hour12 = (hour_s2_reg == 5'd0) ? 5'd12 :
      (pm && hour_s2_reg != 5'd12) ? hour_s2_reg - 5'd12 : hour_s2_reg;
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (addr_phase && !hwrite_in)
      begin
         if (hit_osc)
            rdata_next = {24'h00_0000, osc_next}; // RULE_12
         else if (hit_func)
            rdata_next = {24'h00_0000, func_next};
         else if (hit_status)
            rdata_next = {24'h00_0000, 2'h0, fields.hours, fields.drive,
               fields.cap, 1'b0};
      end
      else
         rdata_next = hrdata_out;
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         src_s1_reg <= 1'b0;
         src_s2_reg <= 1'b0;
         hour_s1_reg <= 5'h00;
         hour_s2_reg <= 5'h00;
      end
      else
      begin
         src_s1_reg <= src_clk_in;
         src_s2_reg <= src_s1_reg;
         hour_s1_reg <= hour_count_in;
         hour_s2_reg <= hour_s1_reg;
      end
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         osc_reg <= `OSC_CTRL_RESET;
         func_reg <= `FUNC_RESET;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_out <= 32'h0000_0000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
      else
      begin
         osc_reg <= osc_next;
         func_reg <= func_next;
         wr_pend_reg <= addr_phase && hwrite_in;
         wr_addr_reg <= word_index;
         hrdata_out <= rdata_next;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         clk_out <= 1'b0;
         low_jitter_select_out <= 1'b0;
         offset_cal_mode_out <= 1'b0;
         crystal_drive_level_out <= DRIVE_NORMAL;
         load_cap_select_out <= CAP_7P0;
         hour_mode_out <= HOURS_24;
         hour_display_out <= 5'h00;
         afternoon_flag_out <= 1'b0;
      end
      else
      begin
         clk_out <= clk_sel ^ fields.invert; // RULE_02 RULE_03
         low_jitter_select_out <= fields.low_jitter_select; // RULE_08
         offset_cal_mode_out <= fields.offset_cal_mode; // RULE_04
         crystal_drive_level_out <= fields.drive; // RULE_09
         load_cap_select_out <= fields.cap; // RULE_10
         hour_mode_out <= fields.hours; // RULE_07
         hour_display_out <= (fields.hours == HOURS_12) ? hour12 :
            hour_s2_reg; // RULE_06
         afternoon_flag_out <= (fields.hours == HOURS_12) && pm; // RULE_06
      end
   end
endmodule

// ---- logic/osc_ctrl_map.svh ----
`ifndef OSC_CTRL_MAP_SVH
`define OSC_CTRL_MAP_SVH
`define OSC_CTRL_ADDR 8'h25
`define FUNC_ADDR 8'h28
`define STATUS_ADDR 8'h40
`define OSC_CTRL_RESET 8'h00
`define FUNC_RESET 8'h00
`define INVERT_BIT 7
`define OFFSET_CAL_MODE_BIT 6
`define HOUR12_BIT 5
`define LOW_JITTER_SELECT_BIT 4
`define DRIVE_HI 3
`define DRIVE_LO 2
`define CAP_HI 1
`define CAP_LO 0
`define COF_HI 2
`define COF_LO 0
`define STOPWATCH_BIT 7
`define ADDR_HI 9
`define ADDR_LO 2
`endif

// ---- logic/osc_ctrl_pkg.sv ----
package osc_ctrl_pkg;
   typedef enum logic [1:0] {DRIVE_NORMAL, DRIVE_LOW, DRIVE_HIGH} drive_t;
   typedef enum logic [1:0] {CAP_7P0, CAP_6P0, CAP_12P5} cap_t;
   typedef enum logic {HOURS_24, HOURS_12} hour_mode_t;
endpackage

// ---- logic/osc_field_if.sv ----
`timescale 1ns/1ns
interface osc_field_if;
   logic [7:0] raw;
   logic stopwatch;
   osc_ctrl_pkg::drive_t drive;
   osc_ctrl_pkg::cap_t cap;
   osc_ctrl_pkg::hour_mode_t hours;
   logic invert;
   logic offset_cal_mode;
   logic low_jitter_select;
   modport src (output raw, output stopwatch,
      input drive, input cap, input hours, input invert, input offset_cal_mode,
      input low_jitter_select);
   modport dec (input raw, input stopwatch,
      output drive, output cap, output hours, output invert, output offset_cal_mode,
      output low_jitter_select);
endinterface

// ---- logic/osc_field_decode.sv ----
`timescale 1ns/1ns
`include "osc_ctrl_map.svh"
module osc_field_decode
(
   osc_field_if.dec f
);
   import osc_ctrl_pkg::*;
   wire [1:0] drive_code;
   wire [1:0] cap_code;
   assign drive_code = f.raw[`DRIVE_HI:`DRIVE_LO];
   assign cap_code = f.raw[`CAP_HI:`CAP_LO];
   assign f.invert = f.raw[`INVERT_BIT]; // RULE_02
   assign f.offset_cal_mode = f.raw[`OFFSET_CAL_MODE_BIT]; // RULE_04
   assign f.low_jitter_select = f.raw[`LOW_JITTER_SELECT_BIT]; // RULE_08
   // Stop-watch mode forces 24 hour counting
   assign f.hours = (f.raw[`HOUR12_BIT] && !f.stopwatch) ?
      HOURS_12 : HOURS_24; // RULE_05 RULE_07
   assign f.drive = (drive_code == 2'h0) ? DRIVE_NORMAL :
      (drive_code == 2'h1) ? DRIVE_LOW : DRIVE_HIGH; // RULE_09
   assign f.cap = (cap_code == 2'h0) ? CAP_7P0 :
      (cap_code == 2'h1) ? CAP_6P0 : CAP_12P5; // RULE_10
endmodule

// ---- testbench/osc_ctrl_properties.sv ----
`timescale 1ns/1ns
module osc_ctrl_properties
   import osc_ctrl_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic hready_in,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic low_jitter_select_out,
   input wire logic offset_cal_mode_out,
   input wire osc_ctrl_pkg::drive_t crystal_drive_level_out,
   input wire osc_ctrl_pkg::cap_t load_cap_select_out,
   input wire osc_ctrl_pkg::hour_mode_t hour_mode_out
);
   // Recent writes to the control word; the jitter, offset, drive and cap outputs may only move after one
   logic [5:0] hist;
   wire wr = hsel_in && hready_in && htrans_in[1] && hwrite_in
      && haddr_in == 32'h0000_0094;
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
         hist <= 6'h00;
      else
         hist <= {hist[4:0], wr};
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   a_ready_okay: assert property (hreadyout_out && !hresp_out)
      else $error("bus answer not ready or not okay");
   a_jit_cause: assert property
      ($changed(low_jitter_select_out) && $past(rstn_in) |-> |hist)
      else $error("low jitter moved without write");
   a_offset_cal_mode_cause: assert property
      ($changed(offset_cal_mode_out) && $past(rstn_in) |-> |hist)
      else $error("offset mode moved without write");
   a_drive_cause: assert property
      ($changed(crystal_drive_level_out) && $past(rstn_in) |-> |hist)
      else $error("drive moved without write");
   a_cap_cause: assert property
      ($changed(load_cap_select_out) && $past(rstn_in) |-> |hist)
      else $error("cap moved without write");
   a_drive_code: assert property (crystal_drive_level_out != 2'h3)
      else $error("drive code out of range");
   a_cap_code: assert property (load_cap_select_out != 2'h3)
      else $error("cap code out of range");
   a_reset_dflt: assert property ($rose(rstn_in) |->
      hour_mode_out == HOURS_24 && !low_jitter_select_out
      && crystal_drive_level_out == DRIVE_NORMAL)
      else $error("defaults wrong after reset");
   c_osc_write: cover property (wr);
   c_hour12: cover property (hour_mode_out == HOURS_12);
   c_drive_high: cover property (crystal_drive_level_out == DRIVE_HIGH);
endmodule
bind osc_ctrl osc_ctrl_properties u_props (.clk_in, .rstn_in, .hsel_in,
   .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out,
   .hresp_out, .low_jitter_select_out, .offset_cal_mode_out,
   .crystal_drive_level_out, .load_cap_select_out, .hour_mode_out);

// ---- testbench/oscillator_control_register_tb_top.sv ----
`timescale 1ns/1ns
module oscillator_control_register_tb_top;
   import osc_ctrl_pkg::*;
   logic clk_in = 1'b0, rstn_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
   logic src_clk_in = 1'b0, hreadyout_out, hresp_out, clk_out;
   logic low_jitter_select_out, offset_cal_mode_out, afternoon_flag_out;
   logic [1:0] htrans_in = 2'h0;
   logic [4:0] hour_count_in = 5'h0F, hour_display_out;
   logic [31:0] haddr_in = 32'h0000_0000, hwdata_in = 32'h0000_0000;
   logic [31:0] hrdata_out, q, v;
   drive_t crystal_drive_level_out;
   cap_t load_cap_select_out;
   hour_mode_t hour_mode_out;
   int fails = 0, n_tests = 0, i, e;
   always #25 clk_in = ~clk_in;
   // Word size fixed; the block ignores it anyway
   osc_ctrl DUT (.clk_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in,
      .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out),
      .src_clk_in, .hour_count_in, .hrdata_out, .hreadyout_out, .hresp_out,
      .clk_out, .low_jitter_select_out, .offset_cal_mode_out,
      .crystal_drive_level_out, .load_cap_select_out, .hour_mode_out,
      .hour_display_out, .afternoon_flag_out);
   task automatic xfer(input logic w, input logic [31:0] a, d);
      @(posedge clk_in);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      hwrite_in <= w;
      haddr_in <= a;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      htrans_in <= 2'h0;
      hwdata_in <= d;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      q = hrdata_out;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic test_done;
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      xfer(1'b0, 32'h0000_0094, 32'h0);
      chk("osc default", 32'h0, q);
      for (i = 0; i < 4; i++)
      begin
         v = {24'h0, i[0], i[1], i[0], i[1], i[1:0], i[1:0]};
         e = (i > 1) ? 2 : i;
         src_clk_in <= i[1];
         xfer(1'b1, 32'h0000_0094, v);
         xfer(1'b0, 32'h0000_0094, 32'h0);
         chk("osc readback", v, q);
         @(negedge clk_in);
         chk("drive", e, crystal_drive_level_out);
         chk("cap", e, load_cap_select_out);
         chk("low jitter", i[1], low_jitter_select_out);
         chk("offset mode", i[1], offset_cal_mode_out);
         chk("hour mode", i[0], hour_mode_out);
         chk("clock out", i[1] ^ i[0], clk_out);
         chk("hour", i[0] ? 5'h03 : 5'h0F, hour_display_out);
         chk("afternoon", i[0], afternoon_flag_out);
      end
      xfer(1'b1, 32'h0000_00A0, 32'h0000_0080);
      xfer(1'b0, 32'h0000_0094, 32'h0);
      @(negedge clk_in);
      chk("stop-watch hours", HOURS_24, hour_mode_out);
      xfer(1'b1, 32'h0000_0098, 32'h0000_0000);
      xfer(1'b0, 32'h0000_0098, 32'h0);
      chk("unmapped", 32'h0, q);
      xfer(1'b0, 32'h0000_0094, 32'h0);
      chk("osc kept", 32'h0000_00FF, q);
      xfer(1'b0, 32'h0000_0100, 32'h0);
      chk("status", 32'h0000_0014, q);
      // Source low so the hour bit stand-in is told apart
      src_clk_in <= 1'b0;
      xfer(1'b1, 32'h0000_00A0, 32'h0000_0001);
      xfer(1'b0, 32'h0000_00A0, 32'h0);
      @(negedge clk_in);
      chk("clock select", 1'b0, clk_out);
      chk("hour mode back", HOURS_12, hour_mode_out);
      chk("bus response", 1'b0, hresp_out);
      test_done;
   end
   initial
   begin
      #100000;
      fails++;
      test_done;
   end
endmodule
